// File: bpt_bank.sv
// Purpose: per-bank open state and close timing counters
// Assumes: commands already decoded and qualified on the same clock
// Notes: counters count down to zero; zero means the limit is met
`timescale 1ns/1ps
module bpt_bank #(
  parameter int CW = 8
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic act,
  input wire logic rd,
  input wire logic wr,
  input wire logic auto_close_flag,
  input wire logic close,
  input wire logic all_close,
  input wire logic [CW-1:0] rd_close_dly,
  input wire logic [CW-1:0] wr_close_dly,
  input wire logic [CW-1:0] single_close_cyc,
  input wire logic [CW-1:0] all_close_cyc,
  input wire logic [CW-1:0] ras_cyc,
  input wire logic [CW-1:0] rc_cyc,
  output logic open,
  output logic ready,
  output logic close_ok,
  output logic auto_fire,
  output logic auto_busy
);
  typedef struct packed
  {
    logic open;
    logic auto_pend;
    logic [CW-1:0] auto_cnt;
    logic [CW-1:0] rp_cnt;
    logic [CW-1:0] ras_cnt;
    logic [CW-1:0] rc_cnt;
    logic [CW-1:0] acc_cnt;
  } bpt_bank_s;
  bpt_bank_s st;
  bpt_bank_s next_st;
  logic fire;

  function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
    dec = (v != '0) ? v - 1'b1 : v;
  endfunction

  // Countdowns and state update
  always_comb
  begin
    next_st = st;
    next_st.auto_cnt = dec(st.auto_cnt);
    next_st.rp_cnt = dec(st.rp_cnt);
    next_st.ras_cnt = dec(st.ras_cnt);
    next_st.rc_cnt = dec(st.rc_cnt);
    next_st.acc_cnt = dec(st.acc_cnt);
    fire = st.auto_pend && (st.auto_cnt <= 1);
    // Limits load one short: the command's own edge is the first cycle
    if (act)
    begin
      next_st.open = 1'b1;
      next_st.ras_cnt = dec(ras_cyc);
      next_st.rc_cnt = dec(rc_cyc);
    end
    if ((rd || wr) && !st.auto_pend)
    begin
      // Longer of read and write spacings kept, never shortened
      if (rd && dec(rd_close_dly) > next_st.acc_cnt)
        next_st.acc_cnt = dec(rd_close_dly);
      if (wr && dec(wr_close_dly) > next_st.acc_cnt)
        next_st.acc_cnt = dec(wr_close_dly);
      if (auto_close_flag)
      begin
        next_st.auto_pend = 1'b1;
        next_st.auto_cnt = rd ? rd_close_dly : wr_close_dly;
      end
    end
    // All-bank close wins over a single close in the same cycle;
    // a close to an idle bank still restarts its close period
    if (all_close)
    begin
      next_st.open = 1'b0;
      next_st.rp_cnt = dec(all_close_cyc);
    end
    else if (close || fire)
    begin
      next_st.open = 1'b0;
      next_st.auto_pend = 1'b0;
      next_st.rp_cnt = dec(single_close_cyc);
    end
    if (all_close)
      next_st.auto_pend = 1'b0;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      auto_fire <= 1'b0;
    end
    else
    begin
      st <= next_st;
      auto_fire <= fire;
    end
  end

  // Bank legal-command view, gate per bank
  assign open = st.open;
  assign auto_busy = st.auto_pend;
  assign ready = !st.open && st.rp_cnt == '0 && st.rc_cnt == '0;
  assign close_ok = st.ras_cnt == '0 && st.acc_cnt == '0;
endmodule

// File: bpt_ctl.sv
// Purpose: controller model driving the command bus
// Assumes: everything changes 2 ns after the rising edge
// Notes: idle bus shows inverted CA so stale bits never decode
`timescale 1ns/1ps
module bpt_ctl (
  input wire logic clock,
  output logic cs_n,
  output logic [9:0] ca_rise,
  output logic [9:0] ca_fall,
  output logic act_valid,
  output logic [2:0] act_bank
);
  // Deselected bus at time zero
  initial
  begin
    cs_n = 1'b1;
    ca_rise = 10'h000;
    ca_fall = 10'h000;
    act_valid = 1'b0;
    act_bank = 3'h0;
  end
  // One bus cycle per call
  task automatic put(input logic sel, input logic [9:0] r,
    input logic [9:0] f, input logic act, input logic [2:0] b);
    @(posedge clock);
    #2;
    cs_n = sel;
    ca_rise = r;
    ca_fall = f;
    act_valid = act;
    act_bank = b;
  endtask
  // CA flips every idle cycle rather than holding old bits
  task automatic idle(input int n);
    repeat (n) put(1'b1, ~ca_rise, ~ca_fall, 1'b0, act_bank);
  endtask
  task automatic activate(input logic [2:0] b);
    put(1'b1, ~ca_rise, ~ca_fall, 1'b1, b);
  endtask
  // CA3..0 1011, CA4 all banks, CA9..7 bank
  task automatic close(input logic all, input logic [2:0] b);
    // Unused CA bits keep toggling so decode cannot lean on them
    put(1'b0, {b, ~ca_rise[6:5], all, 4'hB}, ~ca_fall, 1'b0, b);
  endtask
  // CA0 high, CA1 low, CA2 read; CA0 falling is auto close
  task automatic access(input logic rd, input logic ap,
    input logic [2:0] b);
    // Column bits toggle as on a real bus
    put(1'b0, {b, ~ca_rise[6:3], rd, 2'h1}, {~ca_fall[9:1], ap}, 1'b0,
      b);
  endtask
endmodule

// File: bpt_defs.svh
// Purpose: timing counts and field positions for the bank close timer
// Assumes: 40 MHz command clock, 25 ns period
// Notes: times in ns, cycle counts derived with round-up
`ifndef BPT_DEFS_SVH
`define BPT_DEFS_SVH
`define BPT_CLK_PERIOD_PS 25000
`define BPT_READ_TO_CLOSE_NS 8
`define BPT_WRITE_RECOVERY_NS 15
`define BPT_SINGLE_CLOSE_NS 18
`define BPT_ALL_CLOSE_NS 21
`define BPT_ROW_ACTIVE_NS 42
`define BPT_ROW_CYCLE_NS 60
`define BPT_WRITE_TO_READ_NS 8
`define BPT_STROBE_SKEW_NS 6
`define BPT_RU(ns) (((ns) * 1000 + `BPT_CLK_PERIOD_PS - 1) / `BPT_CLK_PERIOD_PS)
`define BPT_BURST_LENGTH 8
`define BPT_READ_LATENCY 6
`define BPT_WRITE_LATENCY 3
`define BPT_CA_ALL_BANKS 4
`define BPT_CA_BANK_LO 7
`define BPT_CA_AUTO_CLOSE 0
`endif

// File: bpt_pkg.sv
// Purpose: types for the bank close timer
// Assumes: eight banks
// Notes: command decode result carried as one struct
package bpt_pkg;
  typedef enum logic [3:0]
  {
    BPT_NONE = 4'h1,
    BPT_RD = 4'h2,
    BPT_WR = 4'h4,
    BPT_PRE = 4'h8
  } bpt_cmd_e;
  typedef struct packed
  {
    bpt_cmd_e cmd;
    logic all_banks_flag;
    logic auto_close_flag;
    logic [2:0] bank;
    logic act;
  } bpt_dec_s;
endpackage

// File: bpt_top.sv
// Purpose: bank close timing: precharge, auto close and spacing counters
// Assumes: command bus sampled on the command clock edge, no pin sync
// Notes: illegal commands are flagged, not executed
`timescale 1ns/1ps
`include "bpt_defs.svh"
module bpt_top #(
  parameter int CW = 8,
  parameter int BANKS = 8,
  parameter int BURST_LENGTH = `BPT_BURST_LENGTH,
  parameter int READ_LATENCY = `BPT_READ_LATENCY,
  parameter int WRITE_LATENCY = `BPT_WRITE_LATENCY
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic [9:0] ca_rise,
  input wire logic [9:0] ca_fall,
  input wire logic act_valid,
  input wire logic [2:0] act_bank,
  output logic [7:0] bank_open,
  output logic [7:0] bank_ready,
  output logic [7:0] auto_close_busy,
  output logic close_strobe,
  output logic [7:0] close_banks,
  output logic cmd_illegal
);
  localparam int HB = BURST_LENGTH / 2;
  localparam int RTP = `BPT_RU(`BPT_READ_TO_CLOSE_NS);
  localparam int WR_C = `BPT_RU(`BPT_WRITE_RECOVERY_NS);
  localparam int RD_CL = HB + ((RTP > 4) ? RTP : 4) - 4;
  localparam int RD_AP = (HB > HB - 2 + RTP) ? HB : HB - 2 + RTP;
  localparam int WR_CL = WRITE_LATENCY + HB + 1 + WR_C;
  localparam int SB_CL = `BPT_RU(`BPT_SINGLE_CLOSE_NS);
  localparam int AB_CL = `BPT_RU(`BPT_ALL_CLOSE_NS);
  localparam int RAS = `BPT_RU(`BPT_ROW_ACTIVE_NS);
  localparam int RC = `BPT_RU(`BPT_ROW_CYCLE_NS);
  localparam int SKW = `BPT_RU(`BPT_STROBE_SKEW_NS);
  localparam int WTR = `BPT_RU(`BPT_WRITE_TO_READ_NS);
  localparam int RD2WR = READ_LATENCY + HB + SKW - WRITE_LATENCY + 1;
  localparam int WR2RD = WRITE_LATENCY + HB + WTR + 1;

  // Elaboration check: counters must hold the auto close and row cycle spacings
  if (BANKS != 8 || BURST_LENGTH != 8 || RD_AP >= 2 ** CW
      || WR_CL + SB_CL >= 2 ** CW || RC >= 2 ** CW || RD2WR < 1)
  begin : g_bad_param
    $error("bpt_top: parameters out of range");
  end

  typedef struct packed
  {
    logic [7:0] bank_open;
    logic [7:0] bank_ready;
    logic [7:0] auto_close_busy;
    logic close_strobe;
    logic [7:0] close_banks;
    logic cmd_illegal;
    logic last_close;
    logic [CW-1:0] rd_gap;
    logic [CW-1:0] wr_gap;
  } bpt_top_s;
  bpt_top_s st;
  bpt_top_s next_st;
  bpt_pkg::bpt_dec_s d;
  logic [7:0] sel;
  logic [7:0] open_w;
  logic [7:0] ready_w;
  logic [7:0] cok_w;
  logic [7:0] fire_w;
  logic [7:0] busy_w;
  logic [7:0] do_close;
  logic [7:0] do_act;
  logic [7:0] do_rd;
  logic [7:0] do_wr;
  logic do_all;
  logic bad;

  function automatic logic [7:0] onehot(input logic [2:0] b);
    onehot = 8'h01 << b;
  endfunction

  // Command decode on the rising edge sample, auto close flag on the falling one
  always_comb
  begin
    d.cmd = bpt_pkg::BPT_NONE;
    if (!cs_n && ca_rise[0] && ca_rise[1] && !ca_rise[2] && ca_rise[3])
      d.cmd = bpt_pkg::BPT_PRE;
    else if (!cs_n && ca_rise[0] && !ca_rise[1])
      d.cmd = ca_rise[2] ? bpt_pkg::BPT_RD : bpt_pkg::BPT_WR;
    d.all_banks_flag = ca_rise[`BPT_CA_ALL_BANKS];
    d.bank = ca_rise[`BPT_CA_BANK_LO +: 3];
    d.auto_close_flag = ca_fall[`BPT_CA_AUTO_CLOSE];
    d.act = act_valid;
  end

  // Legality checks against per-bank and global spacings
  always_comb
  begin
    // Activate has its own bank lines; commands always use CA bank bits
    sel = onehot(d.bank);
    bad = 1'b0;
    do_all = 1'b0;
    do_close = 8'h00;
    do_act = 8'h00;
    do_rd = 8'h00;
    do_wr = 8'h00;
    unique case (d.cmd)
      bpt_pkg::BPT_PRE:
      begin
        if (st.last_close)
          bad = 1'b1;
        else if (d.all_banks_flag)
          bad = (open_w & ~cok_w) != 8'h00;
        else
          bad = (sel & open_w & ~cok_w) != 8'h00;
      end
      bpt_pkg::BPT_RD:
        bad = (sel & (~open_w | busy_w)) != 8'h00 || st.rd_gap != '0;
      bpt_pkg::BPT_WR:
        bad = (sel & (~open_w | busy_w)) != 8'h00 || st.wr_gap != '0;
      bpt_pkg::BPT_NONE:
        bad = 1'b0;
    endcase
    if (d.act && (onehot(act_bank) & ~ready_w) != 8'h00)
      bad = 1'b1;
    if (!bad)
    begin
      do_all = d.cmd == bpt_pkg::BPT_PRE && d.all_banks_flag;
      do_close = (d.cmd == bpt_pkg::BPT_PRE && !d.all_banks_flag) ? sel : 8'h00;
      do_rd = (d.cmd == bpt_pkg::BPT_RD) ? sel : 8'h00;
      do_wr = (d.cmd == bpt_pkg::BPT_WR) ? sel : 8'h00;
      do_act = d.act ? onehot(act_bank) : 8'h00;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : gb
      bpt_bank #(.CW(CW)) u_bank (
        .clock(clock),
        .arst_n(arst_n),
        .act(do_act[g]),
        .rd(do_rd[g]),
        .wr(do_wr[g]),
        .auto_close_flag(d.auto_close_flag),
        .close(do_close[g]),
        .all_close(do_all),
        .rd_close_dly(CW'(d.auto_close_flag ? RD_AP : RD_CL)),
        .wr_close_dly(CW'(WR_CL)),
        .single_close_cyc(CW'(SB_CL)),
        .all_close_cyc(CW'(AB_CL)),
        .ras_cyc(CW'(RAS)),
        .rc_cyc(CW'(RC)),
        .open(open_w[g]),
        .ready(ready_w[g]),
        .close_ok(cok_w[g]),
        .auto_fire(fire_w[g]),
        .auto_busy(busy_w[g])
      );
    end
  endgenerate

  // Registered status and cross-bank access spacing, loaded only by accesses with auto close
  always_comb
  begin
    next_st = st;
    next_st.bank_open = open_w;
    next_st.bank_ready = ready_w;
    next_st.auto_close_busy = busy_w;
    next_st.cmd_illegal = bad && (d.cmd != bpt_pkg::BPT_NONE || d.act);
    next_st.last_close = d.cmd == bpt_pkg::BPT_PRE && !bad;
    next_st.close_banks = (do_all ? 8'hFF : do_close) | fire_w;
    next_st.close_strobe = do_all || do_close != 8'h00 || fire_w != 8'h00;
    next_st.rd_gap = (st.rd_gap != '0) ? st.rd_gap - 1'b1 : st.rd_gap;
    next_st.wr_gap = (st.wr_gap != '0) ? st.wr_gap - 1'b1 : st.wr_gap;
    // Gap loaded as cycles-1, since the issuing cycle counts as one
    if (do_rd != 8'h00 && d.auto_close_flag)
      next_st.wr_gap = CW'(RD2WR - 1);
    if (do_wr != 8'h00 && d.auto_close_flag)
      next_st.rd_gap = CW'(WR2RD - 1);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign bank_open = st.bank_open;
  assign bank_ready = st.bank_ready;
  assign auto_close_busy = st.auto_close_busy;
  assign close_strobe = st.close_strobe;
  assign close_banks = st.close_banks;
  assign cmd_illegal = st.cmd_illegal;
endmodule

// File: bpt_top_props.sv
// Purpose: timing checks on the bank close ports
// Assumes: default latencies and 25 ns clock
// Notes: auto close windows allow one cycle of register slack
`timescale 1ns/1ps
module bpt_top_props (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic [9:0] ca_rise,
  input wire logic [9:0] ca_fall,
  input wire logic act_valid,
  input wire logic [2:0] act_bank,
  input wire logic [7:0] bank_open,
  input wire logic [7:0] bank_ready,
  input wire logic [7:0] auto_close_busy,
  input wire logic close_strobe,
  input wire logic [7:0] close_banks,
  input wire logic cmd_illegal
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Close command as seen on the rising CA bits
  wire logic cl_cmd = !cs_n && ca_rise[3:0] == 4'hB;
  sequence close_one;
    cl_cmd && !ca_rise[4];
  endsequence
  sequence ap_taken(logic r);
    !cs_n && ca_rise[1:0] == 2'h1 && ca_rise[2] == r && ca_fall[0]
      ##1 !cmd_illegal;
  endsequence
  all_close_a: assert property (cl_cmd && ca_rise[4] ##1 close_strobe
    |-> close_banks == 8'hFF) else $error("all close missed a bank");
  one_close_a: assert property (close_one ##1 (close_strobe && !cmd_illegal)
    |-> close_banks[$past(ca_rise[9:7])]) else $error("wrong bank closed");
  close_gap_a: assert property (cl_cmd ##1 (close_strobe && cl_cmd)
    |=> cmd_illegal) else $error("back to back close taken");
  early_close_a: assert property (act_valid && bank_ready[act_bank]
    ##1 (close_one and (ca_rise[9:7] == $past(act_bank))) |=> cmd_illegal)
    else $error("close before row active time taken");
  illegal_cause_a: assert property (cmd_illegal
    |-> $past(!cs_n || act_valid)) else $error("refusal without command");
  strobe_banks_a: assert property (close_strobe
    |-> close_banks != 8'h00) else $error("close strobe with no bank");
  rd_auto_a: assert property (ap_taken(1'b1)
    |-> ##[3:5] close_strobe) else $error("read auto close late");
  wr_auto_a: assert property (ap_taken(1'b0)
    |-> ##[8:10] close_strobe) else $error("write auto close late");
  // A pending auto close always belongs to a bank that is still open
  busy_open_a: assert property ((auto_close_busy & ~bank_open) == 8'h00)
    else $error("auto close pending on a closed bank");
  reset_clear_a: assert property ($rose(arst_n)
    |-> bank_open == 8'h00 && !close_strobe) else $error("reset state");
endmodule
bind bpt_top bpt_top_props i_props (.clock(clock), .arst_n(arst_n),
  .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall),
  .act_valid(act_valid), .act_bank(act_bank), .bank_open(bank_open),
  .bank_ready(bank_ready), .auto_close_busy(auto_close_busy),
  .close_strobe(close_strobe), .close_banks(close_banks),
  .cmd_illegal(cmd_illegal));

// File: tb.sv
// Purpose: self-checking bench for the bank close timer
// Assumes: default timing set, 40 MHz clock
// Notes: spacings are derived from the same timing defines
`timescale 1ns/1ps
`include "bpt_defs.svh"
module tb;
  localparam int HB = `BPT_BURST_LENGTH / 2;
  localparam int RTP = `BPT_RU(`BPT_READ_TO_CLOSE_NS);
  localparam int RAS = `BPT_RU(`BPT_ROW_ACTIVE_NS);
  localparam int RD_AP = (HB > HB - 2 + RTP) ? HB : HB - 2 + RTP;
  localparam int RD_CL = HB + ((RTP > 4) ? RTP : 4) - 4;
  localparam int WR_CL = `BPT_WRITE_LATENCY + HB + 1
    + `BPT_RU(`BPT_WRITE_RECOVERY_NS);
  logic clock;
  logic arst_n;
  logic cs_n;
  logic [9:0] ca_rise;
  logic [9:0] ca_fall;
  logic act_valid;
  logic [2:0] act_bank;
  logic [7:0] bank_open;
  logic [7:0] bank_ready;
  logic [7:0] auto_close_busy;
  logic close_strobe;
  logic [7:0] close_banks;
  logic cmd_illegal;
  int bad_count = 0;
  int checks = 0;
  bpt_ctl i_ctl (.clock(clock), .cs_n(cs_n), .ca_rise(ca_rise),
    .ca_fall(ca_fall), .act_valid(act_valid), .act_bank(act_bank));
  bpt_top i_dut (.clock(clock), .arst_n(arst_n), .cs_n(cs_n),
    .ca_rise(ca_rise), .ca_fall(ca_fall), .act_valid(act_valid),
    .act_bank(act_bank), .bank_open(bank_open), .bank_ready(bank_ready),
    .auto_close_busy(auto_close_busy), .close_strobe(close_strobe),
    .close_banks(close_banks), .cmd_illegal(cmd_illegal));
  // Free running command clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Idle until the first close strobe; it must land in lo..hi
  task automatic watch(input int lo, input int hi, input logic [7:0] exp);
    int k;
    for (k = 1; k <= hi; k++)
    begin
      i_ctl.idle(1);
      if (close_strobe === 1'b1)
        break;
    end
    check(8'(k >= lo && k <= hi), 8'h01);
    check(close_banks, exp);
  endtask
  task automatic flag(input logic [7:0] exp);
    i_ctl.idle(1);
    check({7'h00, cmd_illegal}, exp);
  endtask
  // Each bank alone, then all banks at once
  task automatic t_close();
    for (int b = 0; b < 8; b++)
    begin
      i_ctl.activate(3'(b));
      i_ctl.idle(RAS);
      check(bank_open, 8'h01 << b);
      i_ctl.close(1'b0, 3'(b));
      watch(1, 1, 8'h01 << b);
      i_ctl.idle(3);
      check(bank_ready & (8'h01 << b), 8'h01 << b);
    end
    i_ctl.activate(3'h0);
    i_ctl.activate(3'h5);
    i_ctl.idle(RAS);
    i_ctl.close(1'b1, 3'h2);
    watch(1, 1, 8'hFF);
    i_ctl.idle(3);
    $display("t_close finished");
  endtask
  // Too early after activate, then closes back to back
  task automatic t_refuse();
    i_ctl.activate(3'h3);
    i_ctl.close(1'b0, 3'h3);
    flag(8'h01);
    i_ctl.activate(3'h4);
    i_ctl.idle(RAS);
    i_ctl.close(1'b0, 3'h3);
    i_ctl.close(1'b0, 3'h4);
    check({7'h00, close_strobe}, 8'h01);
    flag(8'h01);
    i_ctl.close(1'b0, 3'h4);
    watch(1, 1, 8'h10);
    i_ctl.idle(3);
    $display("t_refuse finished");
  endtask
  // Read spacing at its boundary, then read with auto close
  task automatic t_read();
    i_ctl.activate(3'h1);
    i_ctl.activate(3'h2);
    i_ctl.idle(RAS);
    i_ctl.access(1'b1, 1'b0, 3'h1);
    i_ctl.close(1'b0, 3'h1);
    flag(8'h01);
    i_ctl.activate(3'h1);
    flag(8'h01);
    i_ctl.access(1'b1, 1'b0, 3'h1);
    i_ctl.idle(RD_CL - 1);
    check(bank_open & 8'h02, 8'h02);
    i_ctl.close(1'b0, 3'h1);
    watch(1, 1, 8'h02);
    i_ctl.idle(3);
    i_ctl.activate(3'h1);
    i_ctl.idle(RAS);
    i_ctl.access(1'b1, 1'b1, 3'h1);
    i_ctl.access(1'b1, 1'b0, 3'h1);
    flag(8'h01);
    check(auto_close_busy, 8'h02);
    watch(RD_AP, RD_AP, 8'h02);
    // Write to another open bank still inside the read-to-write gap
    i_ctl.access(1'b0, 1'b0, 3'h2);
    flag(8'h01);
    i_ctl.idle(4);
    $display("t_read finished");
  endtask
  // Write spacing at its boundary, then write with auto close
  task automatic t_write();
    i_ctl.activate(3'h7);
    i_ctl.idle(RAS);
    i_ctl.access(1'b0, 1'b0, 3'h7);
    i_ctl.idle(WR_CL - 2);
    i_ctl.close(1'b0, 3'h7);
    flag(8'h01);
    i_ctl.access(1'b0, 1'b0, 3'h7);
    i_ctl.idle(WR_CL - 1);
    i_ctl.close(1'b0, 3'h7);
    watch(1, 1, 8'h80);
    i_ctl.idle(3);
    i_ctl.activate(3'h6);
    i_ctl.activate(3'h5);
    i_ctl.idle(RAS);
    i_ctl.access(1'b0, 1'b1, 3'h6);
    // Read to another bank inside the write-to-read gap
    i_ctl.access(1'b1, 1'b0, 3'h5);
    flag(8'h01);
    watch(WR_CL, WR_CL, 8'h40);
    $display("t_write finished");
  endtask
  // Reset held, then the scenarios in order
  initial
  begin
    arst_n = 1'b0;
    repeat (16) @(posedge clock);
    check(bank_open | auto_close_busy, 8'h00);
    #2 arst_n = 1'b1;
    t_close();
    t_refuse();
    t_read();
    t_write();
    stop_test();
  end
  // Cut a hang well past the expected run of under two hundred cycles
  initial
  begin
    #(25 * 3000);
    bad_count++;
    stop_test();
  end
endmodule
